// File: hdl/sac_pkg.sv
/*
 * Constants and types shared by the converter control block and its
 * successive-approximation sequencer.
 * Assumes a 32-bit APB bus with byte addresses and 8-bit registers.
 */

package sac_pkg;

	// ------------------------------------------------------------
	// register indices and byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] SAC_CTRL_IDX = 8'h34;
	localparam logic [7:0] SAC_RESH_IDX = 8'h35;
	localparam logic [7:0] SAC_RESL_IDX = 8'h36;
	localparam logic [7:0] SAC_ISTAT_IDX = 8'h37;
	localparam logic [7:0] SAC_ICLR_IDX = 8'h38;
	localparam logic [7:0] SAC_IEN_IDX = 8'h39;
	localparam int SAC_AW = 12;
	localparam logic [11:0] SAC_CTRL_ADDR = {2'h0, SAC_CTRL_IDX, 2'h0};
	localparam logic [11:0] SAC_RESH_ADDR = {2'h0, SAC_RESH_IDX, 2'h0};
	localparam logic [11:0] SAC_RESL_ADDR = {2'h0, SAC_RESL_IDX, 2'h0};
	localparam logic [11:0] SAC_ISTAT_ADDR = {2'h0, SAC_ISTAT_IDX, 2'h0};
	localparam logic [11:0] SAC_ICLR_ADDR = {2'h0, SAC_ICLR_IDX, 2'h0};
	localparam logic [11:0] SAC_IEN_ADDR = {2'h0, SAC_IEN_IDX, 2'h0};

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int SAC_EOC_BIT = 7;
	localparam int SAC_SPEED_BIT = 6;
	localparam int SAC_ON_BIT = 5;
	localparam int SAC_CH_MSB = 2;
	localparam int SAC_CH_LSB = 0;
	localparam int SAC_SLOW_BIT = 3;
	localparam int SAC_EV_DONE = 0;
	localparam int SAC_EV_ABORT = 1;

	// ------------------------------------------------------------
	// reset values and counts
	// ------------------------------------------------------------
	localparam logic [7:0] SAC_REG_RST = 8'h00;
	localparam logic [9:0] SAC_RES_RST = 10'h000;
	localparam logic [1:0] SAC_EV_RST = 2'h0;
	localparam logic [2:0] SAC_SAMPLE_TICKS = 3'h4;
	localparam logic [7:0] SAC_FIRST_MASK = 8'h80;
	localparam logic [7:0] SAC_LAST_MASK = 8'h01;
	localparam logic [1:0] SAC_DIV4_LAST = 2'h3;

	typedef enum logic [1:0] {
		SAC_IDLE = 2'b00,
		SAC_SAMPLE = 2'b01,
		SAC_HOLD = 2'b10
	} sac_state_e;

endpackage : sac_pkg

// File: hdl/sac_conv_if.sv
/*
 * Carrier between the register block and the conversion sequencer,
 * including the analog-side signals the sequencer owns.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface sac_conv_if;
	logic run;
	logic restart;
	logic tick;
	logic [2:0] ch_sel;
	logic done;
	logic [9:0] result;
	logic [2:0] ain_select;
	logic sample_en;
	logic hold_en;
	logic [7:0] trial_code;
	logic cmp_above;
	logic [1:0] fine_bits;

	modport ctrl (output run, restart, tick, ch_sel, cmp_above, fine_bits,
		input done, result, ain_select, sample_en, hold_en, trial_code);
	modport eng (input run, restart, tick, ch_sel, cmp_above, fine_bits,
		output done, result, ain_select, sample_en, hold_en, trial_code);
endinterface : sac_conv_if

`default_nettype wire

// File: hdl/sac_sar_engine.sv
/*
 * Conversion sequencer: sample phase, then eight approximation steps
 * in the hold phase, repeated while the converter runs.
 * Assumes the comparator answers within one conversion clock tick.
 */
`timescale 1ns/1ps
`default_nettype none

module sac_sar_engine
	import sac_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	sac_conv_if.eng cif
);

	sac_state_e state, next_state;
	logic [2:0] cnt, next_cnt;
	logic [7:0] mask, next_mask;
	logic [7:0] trial, next_trial;
	logic [7:0] kept;
	logic done, next_done;
	logic [9:0] result, next_result;
	logic [2:0] ain_sel, next_ain_sel;
	logic smp, next_smp;
	logic hld, next_hld;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_mask = mask;
		next_trial = trial;
		next_done = 1'b0;
		next_result = result;
		next_ain_sel = ain_sel;
		next_smp = smp;
		next_hld = hld;
		kept = cif.cmp_above ? trial : (trial & ~mask);
		if (!cif.run)
		begin
			next_state = SAC_IDLE;
			next_smp = 1'b0;
			next_hld = 1'b0;
		end
		else if (cif.restart || state == SAC_IDLE)
		begin
			next_state = SAC_SAMPLE;
			next_cnt = 3'h0;
			next_ain_sel = cif.ch_sel;
			next_smp = 1'b1;
			next_hld = 1'b0;
		end
		else
		begin
			unique case (state)
				SAC_SAMPLE:
					if (cif.tick)
					begin
						if (cnt == SAC_SAMPLE_TICKS - 3'h1)
						begin
							next_state = SAC_HOLD;
							next_mask = SAC_FIRST_MASK;
							next_trial = SAC_FIRST_MASK;
							next_smp = 1'b0;
							next_hld = 1'b1;
						end
						else
							next_cnt = cnt + 3'h1;
					end
				SAC_HOLD:
					if (cif.tick)
					begin
						if (mask == SAC_LAST_MASK)
						begin
							// eight steps done, loop back to sampling
							next_done = 1'b1;
							next_result = {kept, cif.fine_bits};
							next_state = SAC_SAMPLE;
							next_cnt = 3'h0;
							next_ain_sel = cif.ch_sel;
							next_smp = 1'b1;
							next_hld = 1'b0;
						end
						else
						begin
							next_mask = mask >> 1;
							next_trial = kept | (mask >> 1);
						end
					end
				default:
					next_state = SAC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			state <= SAC_IDLE;
			cnt <= 3'h0;
			mask <= 8'h00;
			trial <= 8'h00;
			done <= 1'b0;
			result <= SAC_RES_RST;
			ain_sel <= 3'h0;
			smp <= 1'b0;
			hld <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			mask <= next_mask;
			trial <= next_trial;
			done <= next_done;
			result <= next_result;
			ain_sel <= next_ain_sel;
			smp <= next_smp;
			hld <= next_hld;
		end
	end

	assign cif.done = done;
	assign cif.result = result;
	assign cif.ain_select = ain_sel;
	assign cif.sample_en = smp;
	assign cif.hold_en = hld;
	assign cif.trial_code = trial;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_continuous;
		@(posedge clk) disable iff (!rst_b)
		done && cif.run |-> smp;
	endproperty
	a_continuous: assert property (p_continuous)
		else $error("no new sample after a finished conversion");

	property p_hold_off_sample;
		@(posedge clk) disable iff (!rst_b)
		$rose(hld) |-> !smp && mask == SAC_FIRST_MASK;
	endproperty
	a_hold_off_sample: assert property (p_hold_off_sample)
		else $error("hold phase entered in a wrong way");

endmodule : sac_sar_engine

`default_nettype wire

// File: hdl/sac_adc_ctrl.sv
/*
 * Register block of the 10-bit converter: control/status, result bytes
 * and an event interrupt group over APB; instantiates the sequencer.
 * Assumes an APB master on clk; analog inputs synchronous to clk.
 */
// Our own choice: the APB interface to the registers.
// How it works
// - end flag sets on completion, clears when software reads high byte
// - end flag is read-only; other control bits read and write
// - on bit runs the converter; clearing it stops all activity
// - three-bit field selects one of five analog inputs
// - control write with on set aborts, clears flag, restarts
// - slow and speed bits pick clock divide by 1, 2 or 4
// - high byte is read-only and shows result bits 9 to 2
// - low byte shows bits 1:0, slow at bit 3, zeros elsewhere
// - all converter registers reset to zero
// - wait mode leaves conversion and registers alone
// - halt disables the converter; software waits after wake-up
// - with on set the selected input converts continuously
// - eight approximation steps follow each sample phase
`timescale 1ns/1ps
`default_nettype none

module sac_adc_ctrl
	import sac_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic halt_mode,
	input wire logic cmp_above,
	input wire logic [1:0] fine_bits,
	output logic [2:0] ain_select,
	output logic sample_en,
	output logic hold_en,
	output logic [7:0] trial_code,
	output logic irq
);

	sac_conv_if cif ();

	logic speed, next_speed;
	logic conv_on, next_conv_on;
	logic [2:0] input_select, next_input_select;
	logic slow, next_slow;
	logic eoc, next_eoc;
	logic [9:0] result, next_result;
	logic [1:0] ev_stat, next_ev_stat;
	logic [1:0] ev_en, next_ev_en;
	logic irq_q, next_irq;
	logic [1:0] div_cnt, next_div_cnt;
	logic [31:0] rdata, next_rdata;
	logic rdy, next_rdy;
	logic err, next_err;
	logic setup, acc, wr, rd, hit, ctrl_wr, restart, tick;
	logic [7:0] rmux;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	assign setup = psel && !penable;
	assign acc = psel && penable && rdy;
	assign wr = acc && pwrite && !err;
	assign rd = acc && !pwrite && !err;
	assign hit = paddr == SAC_CTRL_ADDR || paddr == SAC_RESH_ADDR ||
		paddr == SAC_RESL_ADDR || paddr == SAC_ISTAT_ADDR ||
		paddr == SAC_ICLR_ADDR || paddr == SAC_IEN_ADDR;
	assign ctrl_wr = wr && paddr == SAC_CTRL_ADDR;
	assign restart = ctrl_wr && pwdata[SAC_ON_BIT];

	// ------------------------------------------------------------
	// conversion clock
	// ------------------------------------------------------------
	// tick phase is free running; a restart may wait up to three cycles
	assign tick = slow ? (div_cnt == SAC_DIV4_LAST) :
		(speed ? 1'b1 : div_cnt[0]);

	// halt gates the run level only, so registers survive it
	// run and channel follow a control write at once, so a restart
	// samples the newly written input and an off write stops at once
	assign cif.run = next_conv_on && !halt_mode;
	assign cif.restart = restart;
	assign cif.tick = tick;
	assign cif.ch_sel = next_input_select;
	assign cif.cmp_above = cmp_above;
	assign cif.fine_bits = fine_bits;

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always_comb
	begin
		rmux = 8'h00;
		unique case (1'b1)
			paddr == SAC_CTRL_ADDR:
				rmux = {eoc, speed, conv_on, 2'h0, input_select};
			paddr == SAC_RESH_ADDR:
				rmux = result[9:2];
			paddr == SAC_RESL_ADDR:
				rmux = {4'h0, slow, 1'b0, result[1:0]};
			paddr == SAC_ISTAT_ADDR:
				rmux = {6'h00, ev_stat};
			paddr == SAC_IEN_ADDR:
				rmux = {6'h00, ev_en};
			default:
				rmux = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// register next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_speed = speed;
		next_conv_on = conv_on;
		next_input_select = input_select;
		next_slow = slow;
		next_eoc = eoc;
		next_result = result;
		next_ev_stat = ev_stat;
		next_ev_en = ev_en;
		next_div_cnt = div_cnt + 2'h1;
		if (ctrl_wr)
		begin
			// bit 7 of the write is dropped, bits 4:3 are not stored
			next_speed = pwdata[SAC_SPEED_BIT];
			next_conv_on = pwdata[SAC_ON_BIT];
			next_input_select = pwdata[SAC_CH_MSB:SAC_CH_LSB];
		end
		if (wr && paddr == SAC_RESL_ADDR)
			next_slow = pwdata[SAC_SLOW_BIT];
		if (wr && paddr == SAC_IEN_ADDR)
			next_ev_en = pwdata[1:0];
		if (wr && paddr == SAC_ICLR_ADDR)
			next_ev_stat = ev_stat & ~pwdata[1:0];
		// clear with the data capture, so a completion in between is kept
		if (restart || (setup && !pwrite && paddr == SAC_RESH_ADDR))
			next_eoc = 1'b0;
		if (restart && conv_on)
			next_ev_stat[SAC_EV_ABORT] = 1'b1;
		// sets come last so a completion is never lost to a clear
		if (cif.done)
		begin
			next_eoc = 1'b1;
			next_result = cif.result;
			next_ev_stat[SAC_EV_DONE] = 1'b1;
		end
		next_irq = |(next_ev_stat & next_ev_en);
		next_rdy = setup;
		next_err = setup && !hit;
		next_rdata = (setup && !pwrite) ? {24'h000000, rmux} : rdata;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			speed <= 1'b0;
			conv_on <= 1'b0;
			input_select <= 3'h0;
			slow <= 1'b0;
			eoc <= 1'b0;
			result <= SAC_RES_RST;
			ev_stat <= SAC_EV_RST;
			ev_en <= SAC_EV_RST;
			irq_q <= 1'b0;
			div_cnt <= 2'h0;
			rdata <= 32'h00000000;
			rdy <= 1'b0;
			err <= 1'b0;
		end
		else
		begin
			speed <= next_speed;
			conv_on <= next_conv_on;
			input_select <= next_input_select;
			slow <= next_slow;
			eoc <= next_eoc;
			result <= next_result;
			ev_stat <= next_ev_stat;
			ev_en <= next_ev_en;
			irq_q <= next_irq;
			div_cnt <= next_div_cnt;
			rdata <= next_rdata;
			rdy <= next_rdy;
			err <= next_err;
		end
	end

	sac_sar_engine u_engine (
		.clk (clk),
		.rst_b (rst_b),
		.cif (cif.eng)
	);

	assign prdata = rdata;
	assign pready = rdy;
	assign pslverr = err;
	assign irq = irq_q;
	assign ain_select = cif.ain_select;
	assign sample_en = cif.sample_en;
	assign hold_en = cif.hold_en;
	assign trial_code = cif.trial_code;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_eoc_set;
		@(posedge clk) disable iff (!rst_b)
		cif.done |=> eoc;
	endproperty
	a_eoc_set: assert property (p_eoc_set)
		else $error("end flag not set after completion");

	property p_eoc_clear;
		@(posedge clk) disable iff (!rst_b)
		setup && !pwrite && paddr == SAC_RESH_ADDR && !cif.done |=> !eoc;
	endproperty
	a_eoc_clear: assert property (p_eoc_clear)
		else $error("end flag survived a high byte read");

	property p_eoc_ro;
		@(posedge clk) disable iff (!rst_b)
		ctrl_wr && !eoc && !cif.done |=> !eoc;
	endproperty
	a_eoc_ro: assert property (p_eoc_ro)
		else $error("software set the end flag");

	property p_off_quiet;
		@(posedge clk) disable iff (!rst_b)
		!conv_on |-> !sample_en && !hold_en;
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("converter active while off");

	property p_restart;
		@(posedge clk) disable iff (!rst_b)
		restart && !cif.done && !halt_mode |=> !eoc && sample_en &&
			ain_select == $past(pwdata[SAC_CH_MSB:SAC_CH_LSB]);
	endproperty
	a_restart: assert property (p_restart)
		else $error("control write did not restart conversion");

	property p_fast_tick;
		@(posedge clk) disable iff (!rst_b)
		speed && !slow |-> tick;
	endproperty
	a_fast_tick: assert property (p_fast_tick)
		else $error("undivided clock missing a tick");

	property p_slow_tick;
		@(posedge clk) disable iff (!rst_b)
		slow && tick |=> (!tick || !slow) [*3];
	endproperty
	a_slow_tick: assert property (p_slow_tick)
		else $error("divide by four clock ticks too often");

	property p_result_pair;
		@(posedge clk) disable iff (!rst_b)
		cif.done |=> result == $past(cif.result);
	endproperty
	a_result_pair: assert property (p_result_pair)
		else $error("result bytes not updated together");

	property p_low_zero;
		@(posedge clk) disable iff (!rst_b)
		setup && !pwrite && paddr == SAC_RESL_ADDR |=>
			prdata[7:4] == 4'h0 && !prdata[2] && prdata[3] == slow;
	endproperty
	a_low_zero: assert property (p_low_zero)
		else $error("low byte reserved bits not zero");

	property p_reset_zero;
		@(posedge clk)
		!rst_b |=> !eoc && !speed && !conv_on && input_select == 3'h0 &&
			!slow && result == SAC_RES_RST;
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("register not zero after reset");

	property p_halt_off;
		@(posedge clk) disable iff (!rst_b)
		halt_mode |=> !sample_en && !hold_en;
	endproperty
	a_halt_off: assert property (p_halt_off)
		else $error("converter active in halt");

	property p_off_write;
		@(posedge clk) disable iff (!rst_b)
		ctrl_wr && !pwdata[SAC_ON_BIT] |=> !sample_en && !hold_en;
	endproperty
	a_off_write: assert property (p_off_write)
		else $error("write with converter off started a conversion");

	c_done: cover property (@(posedge clk) disable iff (!rst_b)
		cif.done);
	c_abort: cover property (@(posedge clk) disable iff (!rst_b)
		restart && hold_en);
	c_read_clear: cover property (@(posedge clk) disable iff (!rst_b)
		eoc && rd && paddr == SAC_RESH_ADDR);
	c_irq: cover property (@(posedge clk) disable iff (!rst_b) irq);

endmodule : sac_adc_ctrl

`default_nettype wire

// File: bench/sac_analog_model.sv
/*
 * Behavioural stand-in for the multiplexed sample-and-hold and comparator.
 * Assumes the sequencer drives mux select, phase strobes and trial code.
 */
`timescale 1ns/1ps
`default_nettype none

module sac_analog_model
(
	input wire logic clk,
	input wire logic [2:0] ain_select,
	input wire logic sample_en,
	input wire logic hold_en,
	input wire logic [7:0] trial_code,
	input wire logic [49:0] levels,
	output logic cmp_above,
	output logic [1:0] fine_bits
);
	// ------------------------------------------------------------
	// sample capacitor and comparator
	// ------------------------------------------------------------
	logic [9:0] held;
	logic flip = 1'b0;

	// track the selected input while sampling; unused codes give junk
	always @(posedge clk)
	begin
		flip <= ~flip;
		if (sample_en)
			held <= (ain_select > 3'h4) ? ~held : levels[ain_select * 10 +: 10];
	end

	// outside hold the lines toggle, so a read there is never lucky
	assign cmp_above = hold_en ? (held[9:2] >= trial_code) : flip;
	assign fine_bits = hold_en ? held[1:0] : {flip, ~flip};
endmodule : sac_analog_model

`default_nettype wire

// File: bench/test_sac_adc_ctrl.sv
/*
 * Self-checking bench of the converter register block over APB.
 * Assumes the analog model answers the sequencer on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module test_sac_adc_ctrl
	import sac_pkg::*;
();
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic halt_mode = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] st = 32'h35DBEC20;
	logic pready, pslverr, sample_en, hold_en, irq, cmp_above, err;
	logic [2:0] ain_select;
	logic [7:0] trial_code, q;
	logic [1:0] fine_bits;
	logic [49:0] lv = 50'h0;
	logic irq_seen = 1'b0;
	int n_mismatch = 0;
	int compares = 0;
	int hcnt = 0;
	int hold_len = 0;
	logic [11:0] ra [5] = '{SAC_CTRL_ADDR, SAC_RESH_ADDR, SAC_RESL_ADDR,
		SAC_ISTAT_ADDR, SAC_IEN_ADDR};

	sac_adc_ctrl sac_adc_ctrl_inst (.clk(clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.halt_mode(halt_mode), .cmp_above(cmp_above), .fine_bits(fine_bits),
		.ain_select(ain_select), .sample_en(sample_en), .hold_en(hold_en),
		.trial_code(trial_code), .irq(irq));
	sac_analog_model sac_analog_model_inst (.clk(clk),
		.ain_select(ain_select), .sample_en(sample_en), .hold_en(hold_en),
		.trial_code(trial_code), .levels(lv), .cmp_above(cmp_above),
		.fine_bits(fine_bits));

	initial
	begin
		forever #4 clk = ~clk;
	end

	// hold phase length shows the conversion clock divide
	always @(posedge clk)
	begin
		if (irq === 1'b1)
			irq_seen <= 1'b1;
		if (hold_en === 1'b1 && hcnt == 0)
			chk(trial_code, SAC_FIRST_MASK, "first trial");
		if (hold_en === 1'b1)
			hcnt <= hcnt + 1;
		else if (hcnt != 0)
		begin
			hold_len <= hcnt;
			hcnt <= 0;
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function logic [31:0] xs();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction : xs

	function int exp_div(input logic sp, input logic sl);
		return sl ? 4 : (sp ? 1 : 2);
	endfunction : exp_div

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch t=%0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk

	task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the slave
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task poll();
		int n;
		n = 0;
		do
		begin
			apb(1'b0, SAC_CTRL_ADDR, 8'h00);
			n++;
		end
		while (q[7] !== 1'b1 && n < 300);
		if (q[7] !== 1'b1)
			chk(q[7], 1'b1, "poll timeout");
	endtask : poll

	task irq_is(input logic e, input string m);
		repeat (2) @(posedge clk);
		chk(irq, e, m);
	endtask : irq_is

	task summarize();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	initial
	begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		summarize();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		logic [9:0] lvl;
		logic sp, sl;
		logic [2:0] ch;
		logic [7:0] v;
		int d;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b0, ra[i], 8'h00);
			chk(q, 8'h00, "reset value");
		end
		apb(1'b0, 12'h0F0, 8'h00);
		chk({err, q}, 9'h100, "unmapped read");
		v = 8'(xs() & 32'hC7) | 8'h80;
		apb(1'b1, SAC_CTRL_ADDR, v);
		apb(1'b0, SAC_CTRL_ADDR, 8'h00);
		chk(q, v & 8'h47, "ctrl read back");
		chk(prdata, {24'h0, v & 8'h47}, "full word");
		chk(sample_en, 1'b0, "off write idle");
		$display("test registers done");
		for (int i = 0; i < 10; i++)
		begin
			v = 8'(xs());
			lvl = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'(xs());
			ch = 3'(i % 5);
			sl = (i % 3 == 2);
			sp = (i % 3 == 1) | (sl & v[0]);
			d = exp_div(sp, sl);
			// stop first so no stale completion survives the restart
			apb(1'b1, SAC_CTRL_ADDR, 8'h00);
			lv[ch * 10 +: 10] <= lvl;
			apb(1'b1, SAC_RESL_ADDR, {4'hF, sl, 3'h7});
			apb(1'b1, SAC_CTRL_ADDR, {1'b1, sp, 3'h4, ch});
			poll();
			chk(q, {1'b1, sp, 3'h4, ch}, "eoc set");
			chk(ain_select, ch, "mux select");
			if (i % 2 == 0)
			begin
				apb(1'b0, SAC_RESL_ADDR, 8'h00);
				chk(q, {4'h0, sl, 1'b0, lvl[1:0]}, "low byte");
			end
			apb(1'b0, SAC_RESH_ADDR, 8'h00);
			chk(q, lvl[9:2], "high byte");
			chk(hold_len, 8 * d, "hold length");
			// at full rate the next completion may land before this read
			if (d > 1)
			begin
				apb(1'b0, SAC_CTRL_ADDR, 8'h00);
				chk(q[7], 1'b0, "eoc cleared");
			end
		end
		$display("test conversions done");
		poll();
		apb(1'b1, SAC_CTRL_ADDR, 8'h24);
		apb(1'b0, SAC_CTRL_ADDR, 8'h00);
		chk(q, 8'h24, "abort clears eoc");
		apb(1'b0, SAC_ISTAT_ADDR, 8'h00);
		chk(q, 8'h03, "done and abort events");
		poll();
		chk(q[7], 1'b1, "restarted");
		apb(1'b0, SAC_RESH_ADDR, 8'h00);
		poll();
		chk(q[7], 1'b1, "continuous");
		halt_mode <= 1'b1;
		repeat (30) @(posedge clk);
		chk({sample_en, hold_en}, 2'b00, "halt stops");
		apb(1'b0, SAC_CTRL_ADDR, 8'h00);
		chk(q[5], 1'b1, "halt keeps on bit");
		halt_mode <= 1'b0;
		apb(1'b0, SAC_RESH_ADDR, 8'h00);
		poll();
		chk(q[7], 1'b1, "resumes after halt");
		apb(1'b1, SAC_CTRL_ADDR, 8'h04);
		@(posedge clk);
		v = 8'h00;
		repeat (40)
		begin
			@(posedge clk);
			v = v | {6'h0, sample_en, hold_en};
		end
		chk(v, 8'h00, "off stays idle");
		$display("test power done");
		chk(irq_seen, 1'b0, "no request by default");
		apb(1'b1, SAC_IEN_ADDR, 8'h01);
		irq_is(1'b1, "irq enabled");
		apb(1'b1, SAC_IEN_ADDR, 8'h00);
		irq_is(1'b0, "irq masked");
		apb(1'b1, SAC_IEN_ADDR, 8'h02);
		apb(1'b1, SAC_ICLR_ADDR, 8'h03);
		irq_is(1'b0, "irq cleared");
		apb(1'b0, SAC_ISTAT_ADDR, 8'h00);
		chk(q, 8'h00, "status cleared");
		apb(1'b0, SAC_ICLR_ADDR, 8'h00);
		chk(q, 8'h00, "clear reads zero");
		apb(1'b0, SAC_IEN_ADDR, 8'h00);
		chk(q, 8'h02, "enable read back");
		$display("test interrupts done");
		summarize();
	end
endmodule : test_sac_adc_ctrl

`default_nettype wire
